// ### rtl/gro_pkg.sv
// shared constants, codes and decoder for the byte-wide receive link
`default_nettype none

package gro_pkg;

   // -----------------------------------------------------------------
   // receive octet values seen with data valid low and error high
   // -----------------------------------------------------------------
   localparam logic [7:0] GRO_IDLE_OCT    = 8'h00;
   localparam logic [7:0] GRO_LPI_OCT     = 8'h01;
   localparam logic [7:0] GRO_FCAR_OCT    = 8'h0E;
   localparam logic [7:0] GRO_EXT_OCT     = 8'h0F;
   localparam logic [7:0] GRO_EXT_ERR_OCT = 8'h1F;

   // -----------------------------------------------------------------
   // frame octets and link timing
   // -----------------------------------------------------------------
   localparam logic [7:0] GRO_SFD_OCT     = 8'hD5;
   localparam logic [7:0] GRO_PRE_OCT     = 8'h55;
   localparam int         GRO_LINK_DIV    = 8;      // system clocks per link clock

   // one link cycle worth of meaning, used as command and as indication
   typedef enum logic [2:0]
   {
      GRO_C_IDLE     = 3'd0,
      GRO_C_DATA     = 3'd1,
      GRO_C_DATA_ERR = 3'd2,
      GRO_C_EXT      = 3'd3,
      GRO_C_EXT_ERR  = 3'd4,
      GRO_C_FCAR     = 3'd5,
      GRO_C_LPI      = 3'd6
   } gro_code_t;

   // receiver interpretation of the three link signals
   function automatic gro_code_t gro_decode(input logic dv, input logic er, input logic [7:0] d);
      gro_code_t c;
      c = GRO_C_IDLE;
      if (dv)
      begin
         c = er ? GRO_C_DATA_ERR : GRO_C_DATA;
      end
      else if (er)
      begin
         case (d)
            GRO_LPI_OCT:     c = GRO_C_LPI;
            GRO_FCAR_OCT:    c = GRO_C_FCAR;
            GRO_EXT_OCT:     c = GRO_C_EXT;
            GRO_EXT_ERR_OCT: c = GRO_C_EXT_ERR;
            default:         c = GRO_C_IDLE;  // 00 and reserved values are idle
         endcase
      end
      return c;
   endfunction

endpackage

`default_nettype wire

// ### rtl/gro_link_if.sv
// receive link wires between the physical end and the reconciliation end
`default_nettype none

interface gro_link_if;
   logic       rx_clk;
   logic       rx_dv;
   logic       rx_er;
   logic [7:0] rxd;

   modport phy (output rx_clk, output rx_dv, output rx_er, output rxd);
   modport rs  (input rx_clk, input rx_dv, input rx_er, input rxd);
endinterface

`default_nettype wire

// ### rtl/gro_phy_end.sv
// physical-layer end: makes the link clock and presents receive octets
//
// Behaviour
// R1: data valid marks decoded octets, clock-synchronous
// R2: data valid gapless over frame, drops promptly
// R3: valid window starts at SFD, no preamble
// R4: one octet per link cycle, bit0 lsb
// R5: error high with 01 means low power
// R6: error high with 0E means false carrier
// R7: 0F carrier extend, 1F extend error
// R8: both low means idle, any data
// R9: error high with 00 is idle
// R10: error raised on detected frame errors
// R11: error with valid means bad frame
// R12: extension error shown as 1F code
// R13: clean data then extend passes extension up
// R14: extension only directly after frame data
// R15: burst gaps filled with carrier extension
// R16: every frame carries a complete SFD
// R17: no echo of transmit unless loopback
// R18: reserved codes treated as idle
// R19: low power shown steady, ends to idle; code can leave it straight into an SFD frame or false carrier
// R20: halted clock restarts before low power ends
`default_nettype none

module gro_phy_end
   import gro_pkg::*;
#(
   parameter int LINK_DIV = GRO_LINK_DIV
)
(
   input  wire logic       clock,
   input  wire logic       rstn,
   gro_link_if.phy         link,
   input  wire logic       cmd_valid,
   input  wire gro_code_t  cmd_code,
   input  wire logic [7:0] cmd_data,
   output logic            cmd_ready,
   input  wire logic       loop_en,
   input  wire logic       loop_dv,
   input  wire logic       loop_er,
   input  wire logic [7:0] loop_d,
   input  wire logic       clk_stop_en,
   output logic            lpi_shown
);

   // -----------------------------------------------------------------
   // parameters and checks
   // -----------------------------------------------------------------
   localparam int CW   = $clog2(LINK_DIV);
   localparam int HALF = LINK_DIV / 2;
   localparam logic [CW-1:0] CNT_LAST = CW'(LINK_DIV - 1);
   localparam logic [CW-1:0] CNT_SLOT = CW'(HALF - 1);
   localparam logic [CW-1:0] CNT_HALF = CW'(HALF);

   if (LINK_DIV < 4 || (LINK_DIV % 2) != 0)
   begin : g_bad_div
      $error("LINK_DIV must be even and at least 4");
   end

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_FRAME = 3'b001,
      ST_EXT   = 3'b011,
      ST_DROP  = 3'b010,
      ST_LPI   = 3'b110
   } gro_phy_st_t;

   gro_phy_st_t     state;
   gro_phy_st_t     next_state;
   gro_phy_st_t     from;
   gro_code_t       c;
   logic [CW-1:0]   cnt;
   logic [CW-1:0]   next_cnt;
   logic            clk_q;
   logic            dv_q;
   logic            er_q;
   logic [7:0]      d_q;
   logic            next_dv;
   logic            next_er;
   logic [7:0]      next_d;
   logic            slot;
   logic            halt;
   logic            is_data;

   // -----------------------------------------------------------------
   // link clock divider
   // -----------------------------------------------------------------
   // outputs move on the falling edge so the far end has half a period
   assign slot = (cnt == CNT_SLOT);
   // stop only with the clock low and low power still asked for
   assign halt = (state == ST_LPI) && clk_stop_en && (cnt == CNT_HALF)
                 && (!cmd_valid || cmd_code == GRO_C_LPI);

   // counter wraps through 0 (rising edge) before the next update slot
   always_comb
   begin
      if (halt)
         next_cnt = cnt;
      else if (cnt == CNT_LAST)
         next_cnt = '0;                                   // R20
      else
         next_cnt = cnt + CW'(1);
   end

   // divider state and the driven clock
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt   <= '0;
         clk_q <= 1'b1;
      end
      else
      begin
         cnt   <= next_cnt;
         clk_q <= (next_cnt < CNT_HALF);
      end
   end

   // -----------------------------------------------------------------
   // octet sequencing
   // -----------------------------------------------------------------
   // absent command reads as idle, so an underrun ends the frame cleanly
   always_comb
   begin
      c       = cmd_valid ? cmd_code : GRO_C_IDLE;
      is_data = (c == GRO_C_DATA) || (c == GRO_C_DATA_ERR);
      from    = state;
      if ((state == ST_LPI && c != GRO_C_LPI) || (state == ST_DROP && !is_data))
         from = ST_IDLE;                                  // R19
      next_state = ST_IDLE;
      next_dv    = 1'b0;
      next_er    = 1'b0;
      next_d     = GRO_IDLE_OCT;
      case (from)
         ST_IDLE:
         begin
            if (is_data && cmd_data == GRO_SFD_OCT)
            begin
               next_dv    = 1'b1;                         // R3
               next_er    = (c == GRO_C_DATA_ERR);
               next_d     = cmd_data;                     // R16
               next_state = ST_FRAME;
            end
            else if (is_data && cmd_data != GRO_PRE_OCT)
               next_state = ST_DROP;                      // R16
            else if (c == GRO_C_FCAR)
            begin
               next_er = 1'b1;                            // R6
               next_d  = GRO_FCAR_OCT;
            end
            else if (c == GRO_C_LPI)
            begin
               next_er    = 1'b1;                         // R5
               next_d     = GRO_LPI_OCT;
               next_state = ST_LPI;
            end
         end
         ST_FRAME:
         begin
            if (is_data)
            begin
               next_dv    = 1'b1;                         // R2
               next_er    = (c == GRO_C_DATA_ERR);        // R10
               next_d     = cmd_data;                     // R4
               next_state = ST_FRAME;
            end
            else if (c == GRO_C_EXT || c == GRO_C_EXT_ERR)
            begin
               next_er    = 1'b1;                         // R14
               next_d     = (c == GRO_C_EXT) ? GRO_EXT_OCT : GRO_EXT_ERR_OCT;
               next_state = ST_EXT;
            end
         end
         ST_EXT:
         begin
            if (is_data && cmd_data == GRO_SFD_OCT)
            begin
               next_dv    = 1'b1;                         // R15
               next_er    = (c == GRO_C_DATA_ERR);
               next_d     = cmd_data;
               next_state = ST_FRAME;
            end
            else if (is_data && cmd_data == GRO_PRE_OCT)
            begin
               next_er    = 1'b1;                         // R15
               next_d     = GRO_EXT_OCT;
               next_state = ST_EXT;
            end
            else if (is_data)
               next_state = ST_DROP;
            else if (c == GRO_C_EXT || c == GRO_C_EXT_ERR)
            begin
               next_er    = 1'b1;                         // R12
               next_d     = (c == GRO_C_EXT) ? GRO_EXT_OCT : GRO_EXT_ERR_OCT;
               next_state = ST_EXT;
            end
         end
         ST_LPI:
         begin
            next_er    = 1'b1;                            // R19
            next_d     = GRO_LPI_OCT;
            next_state = ST_LPI;
         end
         ST_DROP:
            next_state = ST_DROP;                         // swallow rest of bad frame
         default:
            next_state = ST_IDLE;
      endcase
   end

   // state and link outputs, updated only at the falling-edge slot
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_IDLE;
         dv_q  <= 1'b0;
         er_q  <= 1'b0;
         d_q   <= GRO_IDLE_OCT;
      end
      else if (slot && loop_en)
      begin
         state <= ST_IDLE;                                // R17
         dv_q  <= loop_dv;
         er_q  <= loop_er;
         d_q   <= loop_d;
      end
      else if (slot)
      begin
         state <= next_state;                             // R1
         dv_q  <= next_dv;
         er_q  <= next_er;
         d_q   <= next_d;
      end
   end

   // command handshake and status flags
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_ready <= 1'b0;
         lpi_shown <= 1'b0;
      end
      else
      begin
         cmd_ready <= slot && !loop_en && cmd_valid;      // R17
         lpi_shown <= !dv_q && er_q && (d_q == GRO_LPI_OCT);
      end
   end

   // link pins straight from flops
   assign link.rx_clk = clk_q;
   assign link.rx_dv  = dv_q;
   assign link.rx_er  = er_q;
   assign link.rxd    = d_q;

endmodule // gro_phy_end

`default_nettype wire

// ### rtl/gro_rs_end.sv
// reconciliation end: samples the receive link and decodes each octet
`default_nettype none

module gro_rs_end
   import gro_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      rstn,
   gro_link_if.rs         link,
   output logic           ind_valid,
   output var gro_code_t  ind_code,
   output logic [7:0]     ind_data,
   output logic           lpi_active,
   output logic           frame_end,
   output logic           frame_bad
);

   // -----------------------------------------------------------------
   // synchronisers
   // -----------------------------------------------------------------
   logic [10:0] s1;
   logic [10:0] s2;
   logic        clk_s3;
   logic        rise;
   logic        in_frame;
   logic        err_seen;
   logic        next_err;
   gro_code_t   code;

   // clock and data pass the same two stages, keeping their phase
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s1     <= 11'h400;
         s2     <= 11'h400;
         clk_s3 <= 1'b1;                                  // idle high like the pin, no false rise
      end
      else
      begin
         s1     <= {link.rx_clk, link.rx_dv, link.rx_er, link.rxd};
         s2     <= s1;
         clk_s3 <= s2[10];
      end
   end

   // -----------------------------------------------------------------
   // decode at each link rising edge
   // -----------------------------------------------------------------
   assign rise = s2[10] && !clk_s3;
   assign code = gro_decode(s2[9], s2[8], s2[7:0]);       // R8 R9 R18

   // error flag: a fresh frame clears it, but an error in that octet wins
   always_comb
   begin
      next_err = (in_frame ? err_seen : 1'b0) | (code == GRO_C_DATA_ERR);   // R11
   end

   // indication per link cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ind_valid  <= 1'b0;
         ind_code   <= GRO_C_IDLE;
         ind_data   <= GRO_IDLE_OCT;
         lpi_active <= 1'b0;
      end
      else
      begin
         ind_valid <= rise;                               // R4
         if (rise)
         begin
            ind_code   <= code;                           // R5 R6 R7 R13
            ind_data   <= (code == GRO_C_IDLE || code == GRO_C_LPI || code == GRO_C_FCAR)
                          ? GRO_IDLE_OCT : s2[7:0];
            lpi_active <= (code == GRO_C_LPI);
         end
      end
   end

   // frame tracking; end is seen at the first octet without data valid
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         in_frame  <= 1'b0;
         err_seen  <= 1'b0;
         frame_end <= 1'b0;
         frame_bad <= 1'b0;
      end
      else
      begin
         frame_end <= rise && in_frame && !s2[9];
         if (rise)
         begin
            in_frame <= s2[9];
            if (s2[9])
               err_seen <= next_err;
            if (in_frame && !s2[9])
               frame_bad <= err_seen;                     // R11
         end
      end
   end

endmodule // gro_rs_end

`default_nettype wire

// ### dv/gro_link_assertions.sv
// timing and framing checks on the receive link wires
`default_nettype none

module gro_link_assertions
   import gro_pkg::*;
#(
   parameter int LINK_DIV = GRO_LINK_DIV
)
(
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       rx_clk,
   input wire logic       rx_dv,
   input wire logic       rx_er,
   input wire logic [7:0] rxd
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = LINK_DIV / 2;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // -----------------------------------------------------------------
   // decoded link states
   // -----------------------------------------------------------------
   logic lpi_on;
   logic ext_any;
   // codes only mean something with data valid low
   assign lpi_on  = !rx_dv && rx_er && rxd == GRO_LPI_OCT;
   assign ext_any = !rx_dv && rx_er && (rxd == GRO_EXT_OCT || rxd == GRO_EXT_ERR_OCT);

   sequence lpi_leave;
      lpi_on ##1 !lpi_on;
   endsequence

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   chk_dv_on_fall: assert property ($changed(rx_dv) |-> $fell(rx_clk))
      else $error("data valid moved off a link clock fall");
   chk_er_on_fall: assert property ($changed(rx_er) |-> $fell(rx_clk))
      else $error("error moved off a link clock fall");
   chk_rxd_on_fall: assert property ($changed(rxd) |-> $fell(rx_clk))
      else $error("octet moved off a link clock fall");
   chk_clk_high_half: assert property ($rose(rx_clk) |-> ##HALF $fell(rx_clk))
      else $error("link clock high phase has wrong length");
   // low phase may only stretch while low power is shown
   chk_clk_low_half: assert property ($fell(rx_clk) && !lpi_on |-> ##HALF $rose(rx_clk))
      else $error("link clock stalled outside low power");
   chk_frame_at_sfd: assert property ($rose(rx_dv) |-> rxd == GRO_SFD_OCT)
      else $error("frame window opened on a non delimiter octet");
   chk_ext_after_data: assert property ($fell(rx_clk) && ext_any |-> $past(rx_dv) || $past(ext_any))
      else $error("extension not directly after frame data");
   chk_lpi_exit_idle: assert property (lpi_leave |-> !rx_er && !rx_dv && $past(rx_clk))
      else $error("low power left badly or without a clock rise");
endmodule // gro_link_assertions

`default_nettype wire

// ### dv/gigabit_rx_octet_interface_tb.sv
// testbench joining the physical and reconciliation ends of the receive link
`default_nettype none

module gigabit_rx_octet_interface_tb
   import gro_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic        clock, rstn, cmd_valid, cmd_ready, clk_stop_en, lpi_shown;
   logic        loop_en, loop_dv, loop_er, ind_valid, lpi_active, frame_end, frame_bad;
   logic [7:0]  cmd_data, loop_d, ind_data;
   gro_code_t   cmd_code, ind_code;
   logic        bad_at_end;
   logic [10:0] seen[$];
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          n_idle = 0;
   int          n_rdy = 0;
   int          n_lpi = 0;
   localparam logic [10:0] SFD = {GRO_C_DATA, GRO_SFD_OCT};
   localparam logic [10:0] EXT = {GRO_C_EXT, GRO_EXT_OCT};
   localparam logic [10:0] EXE = {GRO_C_EXT_ERR, GRO_EXT_ERR_OCT};
   localparam logic [10:0] FCR = {GRO_C_FCAR, 8'h00};

   gro_link_if link ();
   gro_phy_end #(.LINK_DIV(GRO_LINK_DIV)) i_gro_phy_end (.clock(clock), .rstn(rstn),
      .link(link), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .loop_en(loop_en), .loop_dv(loop_dv), .loop_er(loop_er),
      .loop_d(loop_d), .clk_stop_en(clk_stop_en), .lpi_shown(lpi_shown));
   gro_rs_end i_gro_rs_end (.clock(clock), .rstn(rstn), .link(link), .ind_valid(ind_valid),
      .ind_code(ind_code), .ind_data(ind_data), .lpi_active(lpi_active),
      .frame_end(frame_end), .frame_bad(frame_bad));
   gro_link_assertions #(.LINK_DIV(GRO_LINK_DIV)) i_chk (.clock(clock), .rstn(rstn),
      .rx_clk(link.rx_clk), .rx_dv(link.rx_dv), .rx_er(link.rx_er), .rxd(link.rxd));

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // collect decoded link cycles; idle ones are only counted
   always @(posedge clock)
   begin
      if (ind_valid === 1'b1 && ind_code === GRO_C_IDLE)
         n_idle++;
      else if (ind_valid === 1'b1)
         seen.push_back({ind_code, ind_data});
      if (frame_end === 1'b1)
         bad_at_end = frame_bad;
      if (cmd_ready === 1'b1)
         n_rdy++;
      if (lpi_active === 1'b1)
         n_lpi++;
   end

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [10:0] got, input logic [10:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [10:0] dat(input logic [7:0] d);
      return {GRO_C_DATA, d};
   endfunction

   // valid is held until the command is taken, as the port requires
   task automatic send(input gro_code_t c, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code  <= c;
      cmd_data  <= d;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (cmd_ready !== 1'b1 && n < 40);
      check(11'(cmd_ready), 11'd1);
   endtask

   // release the port and let the last octet reach the far end
   task automatic go(input logic [10:0] w[$]);
      foreach (w[i])
         send(gro_code_t'(w[i][10:8]), w[i][7:0]);
      @(posedge clock);
      cmd_valid <= 1'b0;
      repeat (32) @(posedge clock);
   endtask

   task automatic expect_seq(input logic [10:0] e[$]);
      check(11'(seen.size()), 11'(e.size()));
      foreach (e[i])
         if (i < seen.size())
            check(seen[i], e[i]);
      seen.delete();
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_refuse();
      go('{EXT, dat(8'h55), dat(8'h77), dat(8'h44)});
      check(11'(seen.size()), 11'd0);
      seen.delete();
   endtask

   task automatic t_frame();
      logic [10:0] c[$];
      c = '{SFD, dat(8'h01), dat(8'h80), dat(8'h3C)};
      go(c);
      expect_seq(c);
      check(11'(bad_at_end), 11'd0);
   endtask

   task automatic t_err_ext();
      logic [10:0] c[$];
      c = '{SFD, {GRO_C_DATA_ERR, 8'h5A}, EXT, EXE};
      go(c);
      expect_seq(c);
      check(11'(bad_at_end), 11'd1);
   endtask

   task automatic t_burst();
      go('{SFD, dat(8'h22), EXT, dat(8'h55), SFD, dat(8'h33)});
      expect_seq('{SFD, dat(8'h22), EXT, EXT, SFD, dat(8'h33)});
   endtask

   task automatic t_fcar();
      go('{FCR, FCR});
      expect_seq('{FCR, FCR});
   endtask

   // clock may halt in low power and must rise once before leaving
   // the halt comes at once, so the far end only learns of low power at the restart rise
   task automatic t_lpi();
      int l0;
      clk_stop_en <= 1'b1;
      send(GRO_C_LPI, 8'h00);
      repeat (48) @(posedge clock);
      check(11'({lpi_active, lpi_shown, link.rx_clk}), 11'd2);
      l0 = n_lpi;
      go('{{GRO_C_IDLE, 8'h00}});
      check(11'({lpi_active, lpi_shown}), 11'd0);
      check(11'(n_lpi - l0), 11'(GRO_LINK_DIV));
      clk_stop_en <= 1'b0;
      expect_seq('{{GRO_C_LPI, 8'h00}});
   endtask

   // loopback puts any code on the wires; commands must stay untaken
   task automatic t_loop();
      logic [9:0] tbl[10];
      int         i0;
      int         r0;
      tbl = '{10'h100, 10'h102, 10'h110, 10'h10E, 10'h120, 10'h1FF, 10'h11E, 10'h101,
              10'h0A7, 10'h10D};
      i0 = n_idle;
      @(posedge clock);
      r0 = n_rdy;
      loop_en   <= 1'b1;
      cmd_valid <= 1'b1;
      cmd_code  <= GRO_C_DATA;
      foreach (tbl[i])
      begin
         {loop_dv, loop_er, loop_d} <= tbl[i];
         repeat (GRO_LINK_DIV) @(posedge clock);
      end
      loop_en   <= 1'b0;
      cmd_valid <= 1'b0;
      repeat (32) @(posedge clock);
      expect_seq('{FCR, {GRO_C_LPI, 8'h00}});
      check(11'(n_idle - i0 >= 8), 11'd1);
      check(11'(n_rdy - r0), 11'd0);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // echo inputs carry junk outside loopback so any echo shows up
   initial
   begin
      rstn        = 1'b0;
      cmd_valid   = 1'b0;
      cmd_code    = GRO_C_IDLE;
      cmd_data    = 8'h00;
      loop_en     = 1'b0;
      loop_dv     = 1'b1;
      loop_er     = 1'b1;
      loop_d      = 8'hEE;
      clk_stop_en = 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      t_refuse();
      t_frame();
      t_err_ext();
      t_burst();
      t_fcar();
      t_lpi();
      t_loop();
      results();
   end

   // watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      #40000;
      n_mismatch++;
      results();
   end
endmodule // gigabit_rx_octet_interface_tb

`default_nettype wire
